// ===== core/pm_host_ctrl.sv
// Host end: register port for software, issues link commands and drives enable
`timescale 1ns/10ps
module pm_host_ctrl (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  pm_link_if.host          link,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output      logic [31:0] reg_rdata
);
  // ****************************************
  // Registers
  // ****************************************
  logic                hold_ff;
  logic [15:0]         wdata_ff;
  logic [15:0]         rdata_ff;
  logic                nack_ff;
  logic [3:0]          tmo_ff;
  pm_pkg::host_state_t state_ff;
  logic                start;

  assign start = reg_wr & (reg_addr == pm_pkg::HREG_CMD) & (state_ff == pm_pkg::H_IDLE);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hold_ff  <= 1'b0;
      wdata_ff <= 16'h0000;
    end else if (reg_wr) begin
      if (reg_addr == pm_pkg::HREG_CTRL) begin
        hold_ff <= reg_wdata[pm_pkg::CTRL_HOLD_BIT];
      end
      if (reg_addr == pm_pkg::HREG_WDATA) begin
        wdata_ff <= reg_wdata[15:0];
      end
    end
  end

  // Holding enable low keeps the device from capturing its address
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      link.en_oe  <= 1'b0;
      link.en_val <= 1'b0;
    end else begin
      link.en_oe  <= hold_ff;
      link.en_val <= 1'b0;
    end
  end

  // ****************************************
  // Transaction engine
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      link.cmd_valid <= 1'b0;
      link.cmd_write <= 1'b0;
      link.cmd_addr  <= 7'h00;
      link.cmd_code  <= 8'h00;
      link.cmd_data  <= 16'h0000;
    end else begin
      link.cmd_valid <= start;
      if (start) begin
        link.cmd_write <= reg_wdata[pm_pkg::CMD_WR_BIT];
        link.cmd_addr  <= reg_wdata[pm_pkg::CMD_ADDR_LSB +: 7];
        link.cmd_code  <= reg_wdata[7:0];
        link.cmd_data  <= wdata_ff;
      end
    end
  end

  // A disabled or absent device never answers; the timeout ends the wait
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_ff <= pm_pkg::H_IDLE;
      tmo_ff   <= 4'h0;
      nack_ff  <= 1'b0;
      rdata_ff <= 16'h0000;
    end else begin
      case (state_ff)
        pm_pkg::H_IDLE: begin
          if (start && !reg_wdata[pm_pkg::CMD_WR_BIT]) begin
            state_ff <= pm_pkg::H_WAIT;
            tmo_ff   <= 4'h0;
            nack_ff  <= 1'b0;
          end else if (start) begin
            nack_ff <= 1'b0;
          end
        end
        pm_pkg::H_WAIT: begin
          if (link.rsp_valid) begin
            rdata_ff <= link.rsp_data;
            state_ff <= pm_pkg::H_IDLE;
          end else if (tmo_ff == pm_pkg::HOST_TMO_CYC - 4'h1) begin
            nack_ff  <= 1'b1;
            state_ff <= pm_pkg::H_IDLE;
          end else begin
            tmo_ff <= tmo_ff + 4'h1;
          end
        end
        default: state_ff <= pm_pkg::H_IDLE;
      endcase
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        pm_pkg::HREG_CTRL:  reg_rdata <= {31'h0, hold_ff};
        pm_pkg::HREG_WDATA: reg_rdata <= {16'h0000, wdata_ff};
        pm_pkg::HREG_STAT:  reg_rdata <= {rdata_ff, 13'h0000, ~link.alert_output_lvl,
                                          nack_ff, (state_ff != pm_pkg::H_IDLE)};
        default:            reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end
endmodule

// ===== core/pm_link_if.sv
// Link between monitor device and management host, with open-drain alert and pulled-up enable
`timescale 1ns/10ps
interface pm_link_if;
  logic        cmd_valid;
  logic        cmd_write;
  logic [6:0]  cmd_addr;
  logic [7:0]  cmd_code;
  logic [15:0] cmd_data;
  logic        rsp_valid;
  logic [15:0] rsp_data;
  logic        alert_output_val;
  logic        alert_output_oe;
  logic        alert_output_lvl;
  logic        en_val;
  logic        en_oe;
  logic        en_lvl;

  // Undriven enable floats high through the pull-up
  assign en_lvl           = en_oe ? en_val : 1'b1;
  assign alert_output_lvl = alert_output_oe ? alert_output_val : 1'b1;

  modport dev (
    input  cmd_valid, cmd_write, cmd_addr, cmd_code, cmd_data, en_lvl,
    output rsp_valid, rsp_data, alert_output_val, alert_output_oe
  );
  modport host (
    output cmd_valid, cmd_write, cmd_addr, cmd_code, cmd_data, en_val, en_oe,
    input  rsp_valid, rsp_data, alert_output_lvl
  );
endinterface

// ===== core/pm_monitor_dev.sv
// Monitor device end: reset control, address strap capture, telemetry and limit checks
//
// Function
// - Enable low: low power, commands ignored
// - Enable low is full reset to defaults
// - Floating enable pulled high, device runs
// - Rail below POR resets like enable
// - Held in reset until both rails good
// - Straps decoded and latched after enable, POR
// - Host holds enable low to redo capture
// - Setup software reset bit resets logic
// - Software reset keeps latched address
// - Diode drive pulses high once per millisecond
// - Read temperature command returns latest code
// - Alert low while temperature above warn limit
// - Fault reported while temperature above fault limit
// - Warn and fault limits host writable
// - Peak power tracking and programmable averaging
// - Warn limits per channel drive alert
// - Range select picks 30 or 60 mV
// - Range select defaults to 30 mV
// - All channels updated every 1 ms
// - Clear faults clears status, rearms snapshot
`timescale 1ns/10ps
module pm_monitor_dev #(
  parameter int RR_CYC_P = pm_pkg::RR_CYC
) (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  pm_link_if.dev                 link,
  input  wire logic              vdd_por_ok,
  input  wire logic              vref_por_ok,
  input  wire logic [1:0]        addr_strap_bit0,
  input  wire logic [1:0]        addr_strap_bit1,
  input  wire logic [1:0]        addr_strap_bit2,
  input  wire logic [4:0][11:0]  adc_chan,
  output      logic              diode_pulse,
  output      logic              current_range,
  output      logic              low_power,
  output      logic [6:0]        bus_addr,
  output      logic              addr_valid
);
  // ****************************************
  // Reset control
  // ****************************************
  logic        en_s1_ff, en_s2_ff, en_ok_ff;
  logic [3:0]  en_cnt_ff;
  logic        swrst_ff;
  logic        por_ok;
  logic        hard_rst;
  logic        func_rst;

  assign por_ok   = vdd_por_ok & vref_por_ok;
  assign hard_rst = rst | ~por_ok | ~en_ok_ff;
  assign func_rst = hard_rst | swrst_ff;

  always_ff @(posedge sys_clk) begin
    if (rst | ~por_ok) begin
      en_s1_ff  <= 1'b0;
      en_s2_ff  <= 1'b0;
      en_ok_ff  <= 1'b0;
      en_cnt_ff <= 4'h0;
    end else begin
      en_s1_ff <= link.en_lvl;
      en_s2_ff <= en_s1_ff;
      // Glitches shorter than the window never reach the reset
      if (en_s2_ff == en_ok_ff) begin
        en_cnt_ff <= 4'h0;
      end else if (en_cnt_ff == pm_pkg::EN_STABLE_CYC - 4'h1) begin
        en_ok_ff  <= en_s2_ff;
        en_cnt_ff <= 4'h0;
      end else begin
        en_cnt_ff <= en_cnt_ff + 4'h1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (hard_rst) begin
      low_power <= 1'b1;
    end else begin
      low_power <= 1'b0;
    end
  end

  // ****************************************
  // Address strap capture
  // ****************************************
  function automatic logic [6:0] trit(input logic [1:0] s);
    trit = (s == pm_pkg::STRAP_HIGH) ? 7'h2 : ((s == pm_pkg::STRAP_GND) ? 7'h0 : 7'h1);
  endfunction

  // Only rst, enable and POR rearm the capture; software reset does not
  always_ff @(posedge sys_clk) begin
    if (hard_rst) begin
      addr_valid <= 1'b0;
      bus_addr   <= 7'h00;
    end else if (!addr_valid) begin
      addr_valid <= 1'b1;
      bus_addr   <= pm_pkg::ADDR_BASE + 7'(trit(addr_strap_bit2) * 7'h9)
                    + 7'(trit(addr_strap_bit1) * 7'h3) + trit(addr_strap_bit0);
    end
  end

  // ****************************************
  // Acquisition round robin
  // ****************************************
  logic [16:0] rr_cnt_ff;
  logic [7:0]  pulse_cnt_ff;
  logic        smp_stb_ff;
  logic        smp_new_ff;

  always_ff @(posedge sys_clk) begin
    if (func_rst) begin
      rr_cnt_ff    <= 17'h0;
      pulse_cnt_ff <= 8'h0;
      diode_pulse  <= 1'b0;
      smp_stb_ff   <= 1'b0;
    end else begin
      smp_stb_ff <= 1'b0;
      if (rr_cnt_ff == 17'(RR_CYC_P - 1)) begin
        rr_cnt_ff    <= 17'h0;
        diode_pulse  <= 1'b1;
        pulse_cnt_ff <= 8'h0;
      end else begin
        rr_cnt_ff <= rr_cnt_ff + 17'h1;
      end
      if (diode_pulse) begin
        pulse_cnt_ff <= pulse_cnt_ff + 8'h1;
        if (pulse_cnt_ff == 8'(pm_pkg::DIODE_PULSE_CYC - 1)) begin
          diode_pulse <= 1'b0;
          smp_stb_ff  <= 1'b1;
        end
      end
    end
  end

  // ****************************************
  // Samples, averages, peak
  // ****************************************
  logic [11:0] smp_ff [pm_pkg::NCH];
  logic [11:0] avg_ff [pm_pkg::NCH];
  logic [11:0] peak_pin_ff;
  logic [2:0]  avg_exp_ff;
  logic [15:0] lim_ff [pm_pkg::NCH];
  logic [15:0] ot_fault_ff;

  always_ff @(posedge sys_clk) begin
    if (func_rst) begin
      smp_new_ff  <= 1'b0;
      peak_pin_ff <= 12'h000;
      for (int i = 0; i < pm_pkg::NCH; i++) begin
        smp_ff[i] <= 12'h000;
        avg_ff[i] <= 12'h000;
      end
    end else begin
      smp_new_ff <= smp_stb_ff;
      if (smp_stb_ff) begin
        for (int i = 0; i < pm_pkg::NCH; i++) begin
          smp_ff[i] <= adc_chan[i];
          avg_ff[i] <= avg_ff[i] + 12'(($signed({1'b0, adc_chan[i]}) - $signed({1'b0, avg_ff[i]})) >>> avg_exp_ff);
        end
        if (adc_chan[pm_pkg::CH_PIN] > peak_pin_ff) begin
          peak_pin_ff <= adc_chan[pm_pkg::CH_PIN];
        end
      end
    end
  end

  // ****************************************
  // Limit checks and status
  // ****************************************
  logic [4:0]  warn_now;
  logic        fault_now;
  logic [7:0]  stat_temp_ff;
  logic [7:0]  stat_mfr_ff;
  logic        snap_armed_ff;
  logic [11:0] snap_temp_ff;
  logic        take;
  logic        clr_faults;

  always_comb begin
    for (int i = 0; i < pm_pkg::NCH; i++) begin
      warn_now[i] = {4'h0, smp_ff[i]} > lim_ff[i];
    end
    fault_now = {4'h0, smp_ff[pm_pkg::CH_TEMP]} > ot_fault_ff;
  end

  assign clr_faults = take & link.cmd_write & (link.cmd_code == pm_pkg::CMD_CLEAR_FAULTS);

  // Set beats clear when both land together
  always_ff @(posedge sys_clk) begin
    if (func_rst) begin
      stat_temp_ff  <= 8'h00;
      stat_mfr_ff   <= 8'h00;
      snap_armed_ff <= 1'b1;
      snap_temp_ff  <= 12'h000;
    end else begin
      if (clr_faults) begin
        stat_temp_ff  <= 8'h00;
        stat_mfr_ff   <= 8'h00;
        snap_armed_ff <= 1'b1;
      end
      if (smp_new_ff) begin
        if (fault_now) begin
          stat_temp_ff[pm_pkg::STAT_OT_FAULT_BIT] <= 1'b1;
        end
        if (warn_now[pm_pkg::CH_TEMP]) begin
          stat_temp_ff[pm_pkg::STAT_OT_WARN_BIT] <= 1'b1;
        end
        stat_mfr_ff[4:0] <= (clr_faults ? 5'h00 : stat_mfr_ff[4:0]) | warn_now;
        if ((|warn_now | fault_now) && snap_armed_ff) begin
          snap_armed_ff <= 1'b0;
          snap_temp_ff  <= smp_ff[pm_pkg::CH_TEMP];
        end
      end
    end
  end

  // Alert follows the live comparison, not the sticky status
  always_ff @(posedge sys_clk) begin
    if (func_rst) begin
      link.alert_output_oe <= 1'b0;
    end else begin
      link.alert_output_oe <= |warn_now;
    end
  end
  assign link.alert_output_val = 1'b0;

  // ****************************************
  // Command handling
  // ****************************************
  logic [15:0] rd_mux;

  assign take = link.cmd_valid & ~low_power & addr_valid & (link.cmd_addr == bus_addr);

  always_ff @(posedge sys_clk) begin
    if (func_rst) begin
      current_range <= 1'b0;
      avg_exp_ff    <= 3'h0;
      ot_fault_ff   <= pm_pkg::OT_FAULT_DEF;
      for (int i = 0; i < pm_pkg::NCH; i++) begin
        lim_ff[i] <= (i == pm_pkg::CH_TEMP) ? pm_pkg::OT_WARN_DEF : pm_pkg::LIM_DEF;
      end
    end else if (take && link.cmd_write) begin
      case (link.cmd_code)
        pm_pkg::CMD_OT_FAULT_LIM: ot_fault_ff <= link.cmd_data;
        pm_pkg::CMD_OT_WARN_LIM:  lim_ff[pm_pkg::CH_TEMP] <= link.cmd_data;
        pm_pkg::CMD_VIN_WARN_LIM: lim_ff[pm_pkg::CH_VIN] <= link.cmd_data;
        pm_pkg::CMD_IIN_WARN_LIM: lim_ff[pm_pkg::CH_IIN] <= link.cmd_data;
        pm_pkg::CMD_PIN_WARN_LIM: lim_ff[pm_pkg::CH_PIN] <= link.cmd_data;
        pm_pkg::CMD_AUX_WARN_LIM: lim_ff[pm_pkg::CH_AUX] <= link.cmd_data;
        pm_pkg::CMD_AVG_CFG:      avg_exp_ff <= link.cmd_data[2:0];
        pm_pkg::CMD_DEVICE_SETUP: current_range <= link.cmd_data[pm_pkg::SETUP_GAIN_BIT];
        default: ;
      endcase
    end
  end

  // One-cycle pulse; the function reset it drives clears it again
  always_ff @(posedge sys_clk) begin
    if (hard_rst | swrst_ff) begin
      swrst_ff <= 1'b0;
    end else begin
      swrst_ff <= take & link.cmd_write & (link.cmd_code == pm_pkg::CMD_DEVICE_SETUP)
                  & link.cmd_data[pm_pkg::SETUP_SWRST_BIT];
    end
  end

  always_comb begin
    rd_mux = 16'h0000;
    case (link.cmd_code)
      pm_pkg::CMD_READ_TEMP:    rd_mux = {4'h0, smp_ff[pm_pkg::CH_TEMP]};
      pm_pkg::CMD_READ_VIN:     rd_mux = {4'h0, smp_ff[pm_pkg::CH_VIN]};
      pm_pkg::CMD_READ_IIN:     rd_mux = {4'h0, smp_ff[pm_pkg::CH_IIN]};
      pm_pkg::CMD_READ_PIN:     rd_mux = {4'h0, smp_ff[pm_pkg::CH_PIN]};
      pm_pkg::CMD_READ_AUX:     rd_mux = {4'h0, smp_ff[pm_pkg::CH_AUX]};
      pm_pkg::CMD_OT_FAULT_LIM: rd_mux = ot_fault_ff;
      pm_pkg::CMD_OT_WARN_LIM:  rd_mux = lim_ff[pm_pkg::CH_TEMP];
      pm_pkg::CMD_VIN_WARN_LIM: rd_mux = lim_ff[pm_pkg::CH_VIN];
      pm_pkg::CMD_IIN_WARN_LIM: rd_mux = lim_ff[pm_pkg::CH_IIN];
      pm_pkg::CMD_PIN_WARN_LIM: rd_mux = lim_ff[pm_pkg::CH_PIN];
      pm_pkg::CMD_AUX_WARN_LIM: rd_mux = lim_ff[pm_pkg::CH_AUX];
      pm_pkg::CMD_STATUS_TEMP:  rd_mux = {8'h00, stat_temp_ff};
      pm_pkg::CMD_STATUS_MFR:   rd_mux = {8'h00, stat_mfr_ff};
      pm_pkg::CMD_DEVICE_SETUP: rd_mux = 16'(current_range) << pm_pkg::SETUP_GAIN_BIT;
      pm_pkg::CMD_AVG_CFG:      rd_mux = {13'h0000, avg_exp_ff};
      pm_pkg::CMD_PEAK_PIN:     rd_mux = {4'h0, peak_pin_ff};
      pm_pkg::CMD_SNAPSHOT:     rd_mux = {4'h0, snap_temp_ff};
      default: begin
        if (link.cmd_code >= pm_pkg::CMD_AVG_BASE && link.cmd_code < pm_pkg::CMD_AVG_BASE + 8'(pm_pkg::NCH)) begin
          rd_mux = {4'h0, avg_ff[3'(link.cmd_code - pm_pkg::CMD_AVG_BASE)]};
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (func_rst) begin
      link.rsp_valid <= 1'b0;
      link.rsp_data  <= 16'h0000;
    end else begin
      link.rsp_valid <= take & ~link.cmd_write;
      link.rsp_data  <= (take & ~link.cmd_write) ? rd_mux : 16'h0000;
    end
  end
endmodule

// ===== core/pm_pkg.sv
// Shared constants and types for the power monitor link, device end and host end
package pm_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam int          CLK_PERIOD_NS   = 10;
  localparam int          RR_TIME_NS      = 1000000;
  localparam int          RR_CYC          = RR_TIME_NS / CLK_PERIOD_NS;
  localparam int          DIODE_PULSE_NS  = 2000;
  localparam int          DIODE_PULSE_CYC = (DIODE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0]  EN_STABLE_CYC   = 4'h4;
  localparam logic [3:0]  HOST_TMO_CYC    = 4'h8;

  // ****************************************
  // Command codes
  // ****************************************
  localparam logic [7:0]  CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0]  CMD_OT_FAULT_LIM = 8'h4f;
  localparam logic [7:0]  CMD_OT_WARN_LIM  = 8'h51;
  localparam logic [7:0]  CMD_VIN_WARN_LIM = 8'h57;
  localparam logic [7:0]  CMD_IIN_WARN_LIM = 8'h5d;
  localparam logic [7:0]  CMD_PIN_WARN_LIM = 8'h6b;
  localparam logic [7:0]  CMD_AUX_WARN_LIM = 8'hd3;
  localparam logic [7:0]  CMD_STATUS_TEMP  = 8'h7d;
  localparam logic [7:0]  CMD_STATUS_MFR   = 8'h80;
  localparam logic [7:0]  CMD_READ_VIN     = 8'h88;
  localparam logic [7:0]  CMD_READ_IIN     = 8'h89;
  localparam logic [7:0]  CMD_READ_AUX     = 8'h8b;
  localparam logic [7:0]  CMD_READ_TEMP    = 8'h8d;
  localparam logic [7:0]  CMD_READ_PIN     = 8'h97;
  localparam logic [7:0]  CMD_AVG_BASE     = 8'hd0;
  localparam logic [7:0]  CMD_DEVICE_SETUP = 8'hd9;
  localparam logic [7:0]  CMD_PEAK_PIN     = 8'hda;
  localparam logic [7:0]  CMD_AVG_CFG      = 8'hdb;
  localparam logic [7:0]  CMD_SNAPSHOT     = 8'hdc;

  // ****************************************
  // Channels, fields, reset values
  // ****************************************
  localparam int          NCH       = 5;
  localparam int          CH_VIN    = 0;
  localparam int          CH_IIN    = 1;
  localparam int          CH_PIN    = 2;
  localparam int          CH_AUX    = 3;
  localparam int          CH_TEMP   = 4;
  localparam logic [15:0] OT_FAULT_DEF = 16'h0960;
  localparam logic [15:0] OT_WARN_DEF  = 16'h07d0;
  localparam logic [15:0] LIM_DEF      = 16'h0fff;
  localparam int          SETUP_GAIN_BIT  = 4;
  localparam int          SETUP_SWRST_BIT = 7;
  localparam int          STAT_OT_FAULT_BIT = 7;
  localparam int          STAT_OT_WARN_BIT  = 6;
  localparam logic [1:0]  STRAP_GND  = 2'h0;
  localparam logic [1:0]  STRAP_OPEN = 2'h1;
  localparam logic [1:0]  STRAP_HIGH = 2'h2;
  localparam logic [6:0]  ADDR_BASE  = 7'h40;

  // ****************************************
  // Host register port
  // ****************************************
  localparam logic [7:0]  HREG_CTRL  = 8'h00;
  localparam logic [7:0]  HREG_CMD   = 8'h04;
  localparam logic [7:0]  HREG_WDATA = 8'h08;
  localparam logic [7:0]  HREG_STAT  = 8'h0c;
  localparam int          CMD_ADDR_LSB  = 8;
  localparam int          CMD_WR_BIT    = 16;
  localparam int          CTRL_HOLD_BIT = 0;
  localparam int          STAT_BUSY_BIT  = 0;

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_WAIT = 2'b01
  } host_state_t;
endpackage

// ===== sim/pm_link_props.sv
// Link checker: watches the signals between host end and device end
`timescale 1ns/10ps
module pm_link_props (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        cmd_valid,
  input wire logic        cmd_write,
  input wire logic        rsp_valid,
  input wire logic [15:0] rsp_data,
  input wire logic        alert_output_val,
  input wire logic        alert_output_oe,
  input wire logic        alert_output_lvl,
  input wire logic        en_val,
  input wire logic        en_oe,
  input wire logic        en_lvl
);
  // ****************
  // Enable low age
  // ****************
  // Saturates past sync and stability window
  logic [3:0] en_low_ff;
  always_ff @(posedge sys_clk) begin
    if (rst || en_lvl) begin
      en_low_ff <= 4'h0;
    end else if (en_low_ff != 4'hf) begin
      en_low_ff <= en_low_ff + 4'h1;
    end
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  a_rsp_after_read: assert property (rsp_valid |-> $past(cmd_valid) && !$past(cmd_write))
    else $error("answer without a read one cycle before");
  a_rsp_one_cycle: assert property (rsp_valid |=> !rsp_valid)
    else $error("answer longer than one cycle");
  a_rsp_idle_zero: assert property (!rsp_valid |-> rsp_data == 16'h0000)
    else $error("answer data outside answer cycle");
  a_write_no_rsp: assert property (cmd_valid && cmd_write |=> !rsp_valid)
    else $error("answer to a write");
  a_disabled_silent: assert property (en_low_ff == 4'hf && cmd_valid |=> !rsp_valid)
    else $error("answer while disabled");
  a_disabled_no_alert: assert property (en_low_ff == 4'hf |-> !alert_output_oe)
    else $error("alert while disabled");
  a_alert_pull_low: assert property (alert_output_oe |-> alert_output_val == 1'b0 && !alert_output_lvl)
    else $error("alert not pulled low");
  a_en_pull_up: assert property (!en_oe |-> en_lvl)
    else $error("floating enable not high");
  a_en_hold_low: assert property (en_oe |-> !en_val && !en_lvl)
    else $error("held enable not low");
  a_cmd_one_cycle: assert property (cmd_valid |=> !cmd_valid)
    else $error("command longer than one cycle");
endmodule

// ===== sim/reset_and_temp_limit_monitor_test.sv
// Bench: host register port drives the link, device outputs and read data checked
`timescale 1ns/10ps
module reset_and_temp_limit_monitor_test;
  typedef struct {logic [31:0] e; logic [31:0] m;} note_t;
  localparam int     RR = 500;
  logic              sys_clk = 1'b0;
  logic              rst = 1'b1;
  logic              vdd_por_ok = 1'b1;
  logic              vref_por_ok = 1'b1;
  logic [1:0]        strap [3] = '{2'h0, 2'h0, 2'h0};
  logic [4:0][11:0]  adc = '0;
  logic [7:0]        reg_addr = 8'h00;
  logic [31:0]       reg_wdata = 32'h0;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic              rd_seen = 1'b0;
  logic [31:0]       reg_rdata;
  logic              diode_pulse, current_range, low_power, addr_valid;
  logic [6:0]        bus_addr, dev_addr;
  int                n_mismatch = 0;
  int                comparisons = 0;
  note_t             nt;
  note_t             q [$];
  pm_link_if pm_link_if_i ();
  pm_monitor_dev #(.RR_CYC_P(RR)) pm_monitor_dev_i (.sys_clk, .rst, .link(pm_link_if_i), .vdd_por_ok, .vref_por_ok,
    .addr_strap_bit0(strap[0]), .addr_strap_bit1(strap[1]), .addr_strap_bit2(strap[2]), .adc_chan(adc), .diode_pulse,
    .current_range, .low_power, .bus_addr, .addr_valid);
  pm_host_ctrl pm_host_ctrl_i (.sys_clk, .rst, .link(pm_link_if_i), .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  pm_link_props pm_link_props_i (.sys_clk, .rst, .cmd_valid(pm_link_if_i.cmd_valid),
    .cmd_write(pm_link_if_i.cmd_write), .rsp_valid(pm_link_if_i.rsp_valid), .rsp_data(pm_link_if_i.rsp_data),
    .alert_output_val(pm_link_if_i.alert_output_val), .alert_output_oe(pm_link_if_i.alert_output_oe),
    .alert_output_lvl(pm_link_if_i.alert_output_lvl), .en_val(pm_link_if_i.en_val),
    .en_oe(pm_link_if_i.en_oe), .en_lvl(pm_link_if_i.en_lvl));
  always #5 sys_clk = ~sys_clk;
  // ****************
  // Tasks
  // ****************
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] got);
    comparisons++;
    if (got !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", name, e, got);
    end
  endtask
  task automatic timeout();
    chk("wait", 32'h1, 32'h0);
    end_of_test();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    logic [31:0] v;
    q.push_back('{e, m});
    rd(a, v);
  endtask
  // Writes leave nack out: only reads can time out
  task automatic cmd(input logic w, input logic [6:0] a, input logic [7:0] c, input logic [15:0] d,
                     input logic nack, input logic [15:0] e, input logic [15:0] m);
    logic [31:0] st;
    wr(pm_pkg::HREG_WDATA, {16'h0000, d});
    wr(pm_pkg::HREG_CMD, {15'h0000, w, 1'b0, a, c});
    for (int i = 0; i < 40; i++) begin
      rd(pm_pkg::HREG_STAT, st);
      if (st[pm_pkg::STAT_BUSY_BIT] === 1'b0) break;
      if (i == 39) timeout();
    end
    chk_rd(pm_pkg::HREG_STAT, {e, 14'h0000, nack, 1'b0}, {m, 14'h0000, !w, 1'b0});
  endtask
  task automatic rdc(input logic [7:0] c, input logic [15:0] e, input logic [15:0] m);
    cmd(1'b0, dev_addr, c, 16'h0, 1'b0, e, m);
  endtask
  task automatic wrc(input logic [7:0] c, input logic [15:0] d);
    cmd(1'b1, dev_addr, c, d, 1'b0, 16'h0, 16'h0);
  endtask
  task automatic run_len(input logic v, output int n);
    n = 0;
    while (diode_pulse === v) begin
      @(posedge sys_clk);
      #1 n++;
      if (n > 1000) timeout();
    end
  endtask
  task automatic wait_smp();
    int n;
    run_len(1'b1, n);
    run_len(1'b0, n);
    run_len(1'b1, n);
    repeat (3) @(posedge sys_clk);
  endtask
  function automatic logic [6:0] addr_of();
    return pm_pkg::ADDR_BASE + 7'(9 * strap[2] + 3 * strap[1] + strap[0]);
  endfunction
  always @(posedge sys_clk) begin
    if (rd_seen && q.size() > 0) begin
      nt = q.pop_front();
      chk("reg_rdata", nt.e, reg_rdata & nt.m);
    end
    rd_seen <= reg_rd;
  end
  // ****************
  // Main sequence
  // ****************
  initial begin
    int w, l;
    logic [11:0] t;
    void'($urandom(12));
    for (int k = 0; k < 5; k++) adc[k] <= 12'($urandom_range(k == pm_pkg::CH_TEMP ? 32'h7d0 : 32'hfff));
    for (int k = 0; k < 3; k++) strap[k] <= 2'($urandom_range(2));
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (12) @(posedge sys_clk);
    dev_addr = addr_of();
    chk("bus_addr", {25'h0, dev_addr}, {25'h0, bus_addr});
    run_len(1'b1, w);
    run_len(1'b0, w);
    run_len(1'b1, w);
    run_len(1'b0, l);
    chk("pulse_width", pm_pkg::DIODE_PULSE_CYC, w);
    chk("pulse_period", RR, w + l);
    cmd(1'b0, dev_addr ^ 7'h01, pm_pkg::CMD_READ_TEMP, 16'h0, 1'b1, 16'h0, 16'h0);
    t = 12'h7d1 + 12'($urandom_range(12'h18e));
    adc[pm_pkg::CH_TEMP] <= t;
    wait_smp();
    rdc(pm_pkg::CMD_READ_TEMP, {4'h0, t}, 16'hffff);
    rdc(pm_pkg::CMD_PEAK_PIN, {4'h0, adc[pm_pkg::CH_PIN]}, 16'hffff);
    chk_rd(pm_pkg::HREG_STAT, 32'h4, 32'h4);
    rdc(pm_pkg::CMD_STATUS_TEMP, 16'h0040, 16'h00c0);
    adc[pm_pkg::CH_TEMP] <= 12'h961 + 12'($urandom_range(12'h69e));
    wait_smp();
    rdc(pm_pkg::CMD_STATUS_TEMP, 16'h00c0, 16'h00c0);
    adc[pm_pkg::CH_TEMP] <= 12'h100;
    wait_smp();
    chk_rd(pm_pkg::HREG_STAT, 32'h0, 32'h4);
    wrc(pm_pkg::CMD_CLEAR_FAULTS, 16'h0);
    rdc(pm_pkg::CMD_STATUS_TEMP, 16'h0000, 16'h00c0);
    wrc(pm_pkg::CMD_OT_WARN_LIM, 16'h0050);
    wrc(pm_pkg::CMD_OT_FAULT_LIM, 16'h0080);
    wait_smp();
    chk_rd(pm_pkg::HREG_STAT, 32'h4, 32'h4);
    rdc(pm_pkg::CMD_STATUS_TEMP, 16'h00c0, 16'h00c0);
    chk("current_range", 32'h0, {31'h0, current_range});
    wrc(pm_pkg::CMD_DEVICE_SETUP, 16'h0010);
    chk("current_range", 32'h1, {31'h0, current_range});
    rdc(pm_pkg::CMD_DEVICE_SETUP, 16'h0010, 16'h0010);
    strap[0] <= strap[0] == 2'h2 ? 2'h0 : strap[0] + 2'h1;
    wrc(pm_pkg::CMD_DEVICE_SETUP, 16'h0080);
    chk("current_range", 32'h0, {31'h0, current_range});
    rdc(pm_pkg::CMD_OT_WARN_LIM, 16'h07d0, 16'hffff);
    chk("bus_addr", {25'h0, dev_addr}, {25'h0, bus_addr});
    wrc(pm_pkg::CMD_OT_WARN_LIM, 16'h0050);
    wr(pm_pkg::HREG_CTRL, 32'h1);
    repeat (12) @(posedge sys_clk);
    chk("low_power", 32'h1, {31'h0, low_power});
    cmd(1'b0, dev_addr, pm_pkg::CMD_READ_TEMP, 16'h0, 1'b1, 16'h0, 16'h0);
    wr(pm_pkg::HREG_CTRL, 32'h0);
    repeat (12) @(posedge sys_clk);
    dev_addr = addr_of();
    chk("bus_addr", {25'h0, dev_addr}, {25'h0, bus_addr});
    rdc(pm_pkg::CMD_OT_WARN_LIM, 16'h07d0, 16'hffff);
    for (int r = 0; r < 2; r++) begin
      vdd_por_ok <= r == 1;
      vref_por_ok <= r == 0;
      repeat (3) @(posedge sys_clk);
      chk("low_power", 32'h1, {31'h0, low_power});
      chk("addr_valid", 32'h0, {31'h0, addr_valid});
      vdd_por_ok <= 1'b1;
      vref_por_ok <= 1'b1;
      repeat (12) @(posedge sys_clk);
      chk("addr_valid", 32'h1, {31'h0, addr_valid});
    end
    end_of_test();
  end
endmodule
